// ---- core/supervisor_pkg.sv ----
package supervisor_pkg;

  // Time base and nominal durations
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned HOLD_TIMEOUT_MS = 215;
  localparam int unsigned WDOG_TIMEOUT_MS = 1500;
  localparam int unsigned NS_PER_MS       = 1000000;

  // Least times round up to whole cycles
  localparam longint unsigned HOLD_CYCLES =
    (longint'(HOLD_TIMEOUT_MS) * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam longint unsigned WDOG_CYCLES =
    (longint'(WDOG_TIMEOUT_MS) * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Counter width for both timeouts
  localparam int unsigned CNT_W = 32;

  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 3;

  // Reset values of synchronised pins (inactive levels)
  localparam logic MANUAL_RST_VAL = 1'b1;
  localparam logic SUPPLY_RST_VAL = 1'b0;

  // Pin positions inside the synchroniser
  localparam int unsigned PIN_PRIMARY   = 0;
  localparam int unsigned PIN_SECONDARY = 1;
  localparam int unsigned PIN_ADJUST    = 2;
  localparam int unsigned PIN_MANUAL    = 3;
  localparam int unsigned PIN_KICK      = 4;
  localparam int unsigned PIN_DRIVEN    = 5;
  localparam int unsigned PIN_COUNT     = 6;

  // Reset values of kick pins and outputs (reset asserted)
  localparam logic KICK_RST_VAL         = 1'b0;
  localparam logic DRIVEN_RST_VAL       = 1'b0;
  localparam logic RESTART_LOW_RST_VAL  = 1'b0;
  localparam logic RESTART_HIGH_RST_VAL = 1'b1;
  localparam logic EXPIRED_RST_VAL      = 1'b0;

endpackage

// ---- core/pin_sync_if.sv ----
`timescale 1ns/1ns
// Raw pin levels in, filtered levels out, between top and synchroniser
interface pin_sync_if #(parameter int unsigned N = 1);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport producer (output raw, input clean);
  modport filter   (input raw, output clean);
endinterface

// ---- core/pin_sync.sv ----
`timescale 1ns/1ns
// Three-stage synchroniser per pin; a change counts once stages two and three agree
module pin_sync #(
  parameter int unsigned N         = 1,
  parameter logic [N-1:0] RST_VAL  = '0
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  pin_sync_if.filter      pins
);

  // Elaboration check: at least one pin
  if (N < 1) begin : g_bad_width
    $error("pin_sync needs at least one pin");
  end

  for (genvar i = 0; i < N; i++) begin : g_pin
    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic clean_q;

    // First stage feeds only the second
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        meta_q  <= RST_VAL[i];
        s2_q    <= RST_VAL[i];
        s3_q    <= RST_VAL[i];
        clean_q <= RST_VAL[i];
      end else begin
        meta_q <= pins.raw[i];
        s2_q   <= meta_q;
        s3_q   <= s2_q;
        if (s2_q == s3_q) begin
          clean_q <= s3_q;  // Agreement filters single-cycle glitches
        end
      end
    end

    assign pins.clean[i] = clean_q;
  end

endmodule

// ---- core/supervisor_reset_watchdog.sv ----
`timescale 1ns/1ns
// Overview of operation
// RULE_01: Reset is asserted while the primary, secondary or adjustable sense reports low.
// RULE_02: Reset is asserted at once and held while the manual clear input is low.
// RULE_03: After manual clear returns high, reset holds for the full hold timeout.
// RULE_04: After supplies recover, reset holds for the hold timeout and ends only with no cause.
// RULE_05: The hold timeout is nominally 215 ms.
// RULE_06: A kick input without edges beyond the watchdog timeout expires it and resets.
// RULE_07: The watchdog timeout from last kick edge or clear is nominally 1.5 s.
// RULE_08: The watchdog counter clears while reset is asserted and on every kick edge.
// RULE_09: The active-high variant drives its output high during reset, same causes and timing.
// RULE_10: A floating or undriven kick input disables the watchdog.
// RULE_11: An unused manual clear input is left open or tied high so it never resets.
// RULE_12: Both timeouts are counted in cycles of the internal clock, set by parameters.
module supervisor_reset_watchdog #(
  parameter longint unsigned HOLD_CYCLES = supervisor_pkg::HOLD_CYCLES,
  parameter longint unsigned WDOG_CYCLES = supervisor_pkg::WDOG_CYCLES,
  parameter bit              ACTIVE_HIGH = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic primary_low,
  input  wire logic secondary_supply_sense,
  input  wire logic adjustable_sense_in,
  input  wire logic manual_clear_in_low,
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_kick_driven,
  output logic      sys_restart_out_low,
  output logic      sys_restart_out,
  output logic      watchdog_expired
);

  localparam int unsigned W = supervisor_pkg::CNT_W;

  // Elaboration checks: a timeout must fit the counter width
  if (HOLD_CYCLES < 1 || HOLD_CYCLES >= (64'h1 << W)) begin : g_bad_hold
    $error("HOLD_CYCLES out of range");
  end
  if (WDOG_CYCLES < 1 || WDOG_CYCLES >= (64'h1 << W)) begin : g_bad_wdog
    $error("WDOG_CYCLES out of range");
  end

  localparam logic [W-1:0] HOLD_LAST = W'(HOLD_CYCLES - 1);
  localparam logic [W-1:0] WDOG_LAST = W'(WDOG_CYCLES - 1);

  // Gray codes along held, holdoff, run
  typedef enum logic [1:0] {
    ST_HELD    = 2'b00,
    ST_HOLDOFF = 2'b01,
    ST_RUN     = 2'b11
  } rst_state_e;

  localparam int unsigned PINS = supervisor_pkg::PIN_COUNT;

  // Reset levels are the inactive ones, so no cause shows during reset
  // Concatenations list the highest pin position first
  localparam logic [PINS-1:0] PIN_RST = {supervisor_pkg::DRIVEN_RST_VAL,
                                         supervisor_pkg::KICK_RST_VAL,
                                         supervisor_pkg::MANUAL_RST_VAL,
                                         supervisor_pkg::SUPPLY_RST_VAL,
                                         supervisor_pkg::SUPPLY_RST_VAL,
                                         supervisor_pkg::SUPPLY_RST_VAL};

  pin_sync_if #(.N(PINS)) pins ();

  // Every pin is asynchronous to clk, so all pass the synchroniser
  assign pins.raw = {watchdog_kick_driven,
                     watchdog_kick_in,
                     manual_clear_in_low,
                     adjustable_sense_in,
                     secondary_supply_sense,
                     primary_low};

  pin_sync #(
    .N       (PINS),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pins  (pins.filter)
  );

  logic supplyLow;
  logic manualLow;
  logic kickLevel;
  logic kickDriven;
  logic causeActive;

  // Any live cause forces reset immediately
  assign supplyLow   = pins.clean[supervisor_pkg::PIN_PRIMARY]
                     | pins.clean[supervisor_pkg::PIN_SECONDARY]
                     | pins.clean[supervisor_pkg::PIN_ADJUST];  // RULE_01
  assign manualLow   = ~pins.clean[supervisor_pkg::PIN_MANUAL];  // RULE_02 RULE_11
  assign kickLevel   = pins.clean[supervisor_pkg::PIN_KICK];
  assign kickDriven  = pins.clean[supervisor_pkg::PIN_DRIVEN];

  // Sequencer state, counters and watchdog decode
  rst_state_e    state_q;
  rst_state_e    state_d;
  logic [W-1:0]  holdCnt_q;
  logic [W-1:0]  wdogCnt_q;
  logic          kickPrev_q;
  logic          expire;
  logic          kickEdge;
  logic          inReset;
  logic          holdDone;
  logic          wdogDone;
  logic          restartNext;

  // Expiry is a cause as well; inReset also gates the watchdog
  assign causeActive = supplyLow | manualLow | expire;
  assign inReset     = (state_q != ST_RUN);
  assign kickEdge    = kickLevel ^ kickPrev_q;

  // Terminal counts, one word-wide compare each
  assign holdDone    = (holdCnt_q == HOLD_LAST);
  assign wdogDone    = (wdogCnt_q == WDOG_LAST);

  // Both output polarities follow the next state, so they never disagree
  assign restartNext = (state_d != ST_RUN);

  // Next state of the reset sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_HELD: begin
        if (!causeActive) begin
          state_d = ST_HOLDOFF;  // RULE_03 RULE_04
        end
      end
      ST_HOLDOFF: begin
        if (causeActive) begin
          state_d = ST_HELD;  // A returning cause restarts the whole hold
        end else if (holdDone) begin
          state_d = ST_RUN;  // RULE_04
        end
      end
      ST_RUN: begin
        if (causeActive) begin
          state_d = ST_HELD;  // RULE_01 RULE_02 RULE_06
        end
      end
      default: state_d = ST_HELD;
    endcase
  end

  // Power-on counts as a cause: reset then holds for the timeout
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_HELD;
    end else begin
      state_q <= state_d;
    end
  end

  // Hold counter runs only while cause-free in holdoff
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      holdCnt_q <= '0;
    end else if (state_q == ST_HOLDOFF && !causeActive) begin
      holdCnt_q <= holdCnt_q + W'(1);  // RULE_05 RULE_12
    end else begin
      holdCnt_q <= '0;
    end
  end

  // Edge detector reads the filtered level, never a raw stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      kickPrev_q <= supervisor_pkg::KICK_RST_VAL;  // Same as pin reset: no false edge
    end else begin
      kickPrev_q <= kickLevel;
    end
  end

  // Watchdog count; expiry is a one-cycle cause that starts a full hold
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wdogCnt_q <= '0;
    end else if (inReset || kickEdge || !kickDriven) begin
      wdogCnt_q <= '0;  // RULE_08 RULE_10
    end else if (!wdogDone) begin
      wdogCnt_q <= wdogCnt_q + W'(1);  // RULE_07 RULE_12
    end else begin
      wdogCnt_q <= '0;
    end
  end

  assign expire = !inReset && kickDriven && !kickEdge && wdogDone;  // RULE_06

  // Active-low reset output, asserted from the first reset edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_restart_out_low <= supervisor_pkg::RESTART_LOW_RST_VAL;
    end else begin
      sys_restart_out_low <= ~restartNext;  // RULE_01 RULE_02
    end
  end

  // Active-high variant; same causes and timing, opposite level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sys_restart_out <= supervisor_pkg::RESTART_HIGH_RST_VAL;
    end else begin
      sys_restart_out <= restartNext;  // RULE_09
    end
  end

  // Expiry flag is registered so it lines up with the reset edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      watchdog_expired <= supervisor_pkg::EXPIRED_RST_VAL;
    end else begin
      watchdog_expired <= expire;  // RULE_06
    end
  end

  // ACTIVE_HIGH only documents the variant; both pins are provided
  // A board uses the pin of its variant and leaves the other open
  logic unusedVariant;
  assign unusedVariant = ACTIVE_HIGH;

endmodule

// ---- test/processor_model.sv ----
`timescale 1ns/1ns
// Processor side: kicks the watchdog while it runs out of reset
module processor_model (
  input  wire logic       clk,
  input  wire logic       restartLow,
  input  wire logic       attach,
  input  wire logic [7:0] period,
  output logic            kick,
  output logic            kickDriven
);
  logic [7:0] cnt;
  initial begin
    kick = 1'h0;
    cnt = 8'h00;
  end
  assign kickDriven = attach;
  // Period zero is a hung program; a released pin wiggles so no stale level helps
  always @(negedge clk) begin
    cnt <= cnt + 8'h01;
    if (!attach) begin
      kick <= !kick;
    end else if (restartLow && period != 8'h00 && cnt >= period) begin
      kick <= !kick;
      cnt <= 8'h00;
    end
  end
endmodule

// ---- test/supervisor_sva.sv ----
`timescale 1ns/1ns
module supervisor_sva #(
  parameter longint unsigned HOLD_CYCLES = 50,
  parameter longint unsigned WDOG_CYCLES = 200
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic primary_low,
  input wire logic secondary_supply_sense,
  input wire logic adjustable_sense_in,
  input wire logic manual_clear_in_low,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_driven,
  input wire logic sys_restart_out_low,
  input wire logic sys_restart_out,
  input wire logic watchdog_expired
);
  logic [31:0] quietQ;
  logic [31:0] stillQ;
  logic        cause;
  assign cause = primary_low || secondary_supply_sense || adjustable_sense_in;
  // Cycles since the last cause; expiry counts as one
  always_ff @(posedge clk) begin
    if (!rst_n || cause || !manual_clear_in_low || watchdog_expired) quietQ <= '0;
    else quietQ <= quietQ + 32'h1;
  end
  // Cycles the kick pin sat still while supervised
  always_ff @(posedge clk) begin
    if (!rst_n || !sys_restart_out_low || !watchdog_kick_driven) stillQ <= '0;
    else if (watchdog_kick_in != $past(watchdog_kick_in)) stillQ <= '0;
    else stillQ <= stillQ + 32'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_OUT_PAIR: assert property (sys_restart_out == !sys_restart_out_low)
    else $error("Reset outputs not complementary");
  AST_SUPPLY: assert property (cause [*6] |-> !sys_restart_out_low)
    else $error("Supply cause without reset");
  AST_MANUAL: assert property (!manual_clear_in_low [*6] |-> !sys_restart_out_low)
    else $error("Manual clear without reset");
  AST_HOLD_MIN: assert property ($rose(sys_restart_out_low) |-> quietQ + 2 >= HOLD_CYCLES)
    else $error("Reset released before hold");
  AST_HOLD_MAX: assert property (quietQ == HOLD_CYCLES + 8 |-> sys_restart_out_low)
    else $error("Reset kept past hold");
  AST_WDOG_MAX: assert property (stillQ < WDOG_CYCLES + 8)
    else $error("Watchdog failed to expire");
  AST_WDOG_MIN: assert property ($rose(watchdog_expired) |-> stillQ + 2 >= WDOG_CYCLES)
    else $error("Watchdog expired early");
  AST_EXP_RESET: assert property (watchdog_expired |-> ##[0:1] !sys_restart_out_low)
    else $error("Expiry without reset");
  AST_EXP_PULSE: assert property (watchdog_expired |=> !watchdog_expired)
    else $error("Expiry pulse too long");
  cover property ($rose(sys_restart_out_low));
  cover property ($rose(watchdog_expired));
  cover property (!manual_clear_in_low [*6]);
  cover property (cause [*6]);
endmodule
bind supervisor_reset_watchdog supervisor_sva #(.HOLD_CYCLES(HOLD_CYCLES),
  .WDOG_CYCLES(WDOG_CYCLES)) supervisor_sva_inst (.clk(clk), .rst_n(rst_n),
  .primary_low(primary_low), .secondary_supply_sense(secondary_supply_sense),
  .adjustable_sense_in(adjustable_sense_in), .manual_clear_in_low(manual_clear_in_low),
  .watchdog_kick_in(watchdog_kick_in), .watchdog_kick_driven(watchdog_kick_driven),
  .sys_restart_out_low(sys_restart_out_low), .sys_restart_out(sys_restart_out),
  .watchdog_expired(watchdog_expired));

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
  localparam longint unsigned HOLD = 50;
  localparam longint unsigned WDOG = 200;
  logic       clk = 1'h0, rst_n = 1'h0, pLow = 1'h0, sLow = 1'h0, aLow = 1'h0;
  logic       manLow = 1'h1, attach = 1'h1, kick, driven, outLow, outHigh, expired;
  logic [7:0] period = 8'h14;
  int         n_errors = 0, samples_checked = 0, nExp = 0, n;
  always #5 clk = !clk;
  always @(posedge clk) if (expired === 1'h1) nExp++;
  supervisor_reset_watchdog #(.HOLD_CYCLES(HOLD), .WDOG_CYCLES(WDOG))
    supervisor_reset_watchdog_inst (.clk(clk), .rst_n(rst_n), .primary_low(pLow),
    .secondary_supply_sense(sLow), .adjustable_sense_in(aLow), .manual_clear_in_low(manLow),
    .watchdog_kick_in(kick), .watchdog_kick_driven(driven), .sys_restart_out_low(outLow),
    .sys_restart_out(outHigh), .watchdog_expired(expired));
  processor_model processor_model_inst (.clk(clk), .restartLow(outLow), .attach(attach),
    .period(period), .kick(kick), .kickDriven(driven));
  task automatic check(string what, logic seen, logic exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Cycles until the output reaches lvl; bounded so a hang ends the run
  task automatic gap(logic lvl);
    n = 0;
    while (outLow !== lvl) begin
      @(negedge clk);
      n++;
      if (n > 2000) begin
        n_errors++;
        $display("ERROR wait expected %b seen %b", lvl, outLow);
        tally_and_finish();
      end
    end
  endtask
  task automatic held(string what);
    gap(1'h1);
    check(what, n >= HOLD && n <= HOLD + 12, 1'h1);
  endtask
  // Each supply cause alone
  task automatic supplies();
    for (int i = 0; i < 3; i++) begin
      {pLow, sLow, aLow} = 3'h4 >> i;
      gap(1'h0);
      check("assert delay", n <= 8, 1'h1);
      check("high variant", outHigh, 1'h1);
      repeat (HOLD / 5) @(negedge clk);
      check("supply held", outLow, 1'h0);
      {pLow, sLow, aLow} = 3'h0;
      held("supply hold");
    end
  endtask
  // Long press, then a supply dip in mid-hold restarts the count
  task automatic manual();
    manLow = 1'h0;
    gap(1'h0);
    repeat (HOLD * 2) @(negedge clk);
    check("manual held", outLow, 1'h0);
    manLow = 1'h1;
    repeat (HOLD / 2) @(negedge clk);
    check("manual hold", outLow, 1'h0);
    pLow = 1'h1;
    repeat (4) @(negedge clk);
    pLow = 1'h0;
    held("restarted hold");
  endtask
  task automatic watchdog();
    repeat (WDOG * 3) @(negedge clk);
    check("kicked alive", outLow === 1'h1 && nExp == 0, 1'h1);
    period = 8'h00;
    gap(1'h0);
    check("expiry time", n + 20 >= WDOG && n <= WDOG + 12, 1'h1);
    period = 8'h14;
    held("expiry hold");
    check("expiry pulse", nExp == 1, 1'h1);
    attach = 1'h0;
    repeat (WDOG * 3) @(negedge clk);
    check("floating kick", outLow, 1'h1);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    check("in reset", outLow, 1'h0);
    rst_n = 1'h1;
    held("powerup hold");
    supplies();
    manual();
    watchdog();
    tally_and_finish();
  end
endmodule
